// ===== design/rld_ladder_control.sv
// Register file and switch control of the resistor-ladder reference
// Assumes a plain register port, synchronous pins and one 125 MHz clock
`timescale 1ns/1ps
module rld_ladder_control
  import rld_pkg::*;
#(
  parameter int CODE_W = RLD_CODE_W
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic [3:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [7:0]             reg_rdata,
  input  wire logic                   pin_digital_in,
  input  wire logic                   pin_port_out,
  input  wire logic                   pin_port_oe_n,
  output logic                        pin_read_value,
  output logic                        pin_drv_out,
  output logic                        pin_drv_oe_n,
  output logic                        pin_input_enable,
  output logic                        pin_analog_connect,
  output logic                        ladder_active,
  output logic                        pos_end_connect,
  output logic                        neg_end_connect,
  output logic      [1:0]             positive_source_select,
  output logic                        negative_source_select,
  output logic      [CODE_W-1:0]      level_code,
  output logic      [(1<<CODE_W)-1:0] tap_sel,
  output logic                        comparator_ref_valid,
  output logic                        converter_ch_valid
);
  // ****************************************
  // Decode helpers
  // ****************************************
  // Strobe qualified by register index; shared by both register writes
  function automatic logic rld_hit(input logic strobe, input logic [3:0] addr,
                                   input logic [3:0] off);
    return strobe && addr == off;
  endfunction : rld_hit

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] ref_ladder_control_r;
  logic [7:0] ref_ladder_level_r;
  logic [7:0] reg_rdata_r;

  // Control register; no sleep input exists, so wake leaves it as is
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ref_ladder_control_r <= RLD_CONTROL_RST;
    end else if (rld_hit(reg_wr, reg_addr, RLD_CONTROL_OFF)) begin
      ref_ladder_control_r <= reg_wdata & RLD_CONTROL_MSK;
    end
  end

  // Level register, five bits used
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ref_ladder_level_r <= RLD_LEVEL_RST;
    end else if (rld_hit(reg_wr, reg_addr, RLD_LEVEL_OFF)) begin
      ref_ladder_level_r <= reg_wdata & RLD_LEVEL_MSK;
    end
  end

  // Read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        RLD_CONTROL_OFF: reg_rdata_r <= ref_ladder_control_r;
        RLD_LEVEL_OFF:   reg_rdata_r <= ref_ladder_level_r;
        default:         reg_rdata_r <= 8'h00;
      endcase
    end else begin
      reg_rdata_r <= 8'h00;
    end
  end
  assign reg_rdata = reg_rdata_r;

  // ****************************************
  // Ladder control
  // ****************************************
  logic en;
  logic lps;
  logic oe;
  assign en  = ref_ladder_control_r[RLD_EN_BIT];
  assign lps = ref_ladder_control_r[RLD_LPS_BIT];
  assign oe  = ref_ladder_control_r[RLD_OE_BIT];

  assign ladder_active          = en;
  assign level_code             = ref_ladder_level_r[CODE_W-1:0];
  assign positive_source_select = ref_ladder_control_r[RLD_PSS_LSB +: 2];
  assign negative_source_select = ref_ladder_control_r[RLD_NSS_BIT];
  // Disabled ladder keeps one end tied so the output clamps with no current
  assign pos_end_connect = en | lps;
  assign neg_end_connect = en | ~lps;

  // Tap selection stays live while disabled so the clamp passes the end
  rld_switch_decode #(.CODE_W(CODE_W)) u_dec (
    .code    (level_code),
    .active  (1'b1),
    .tap_sel (tap_sel)
  );

  // Level fans out to comparator, converter channel and pin
  assign comparator_ref_valid = en | ~lps | lps;
  assign converter_ch_valid   = comparator_ref_valid;

  // ****************************************
  // Output pin override
  // ****************************************
  assign pin_analog_connect = oe;
  // Output enable is low while driving; forced high to release the pin
  assign pin_drv_oe_n     = oe ? 1'b1 : pin_port_oe_n;
  assign pin_drv_out      = oe ? 1'b0 : pin_port_out;
  assign pin_input_enable = ~oe;
  assign pin_read_value   = oe ? 1'b0 : pin_digital_in;

  // ****************************************
  // Checks
  // ****************************************
  property p_write_ctrl;
    @(posedge ref_clk) disable iff (rst)
    reg_wr && reg_addr == RLD_CONTROL_OFF |=>
      ref_ladder_control_r == ($past(reg_wdata) & RLD_CONTROL_MSK);
  endproperty
  a_write_ctrl: assert property (p_write_ctrl) else $error("control write lost");

  property p_read_level;
    @(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == RLD_LEVEL_OFF && !reg_wr |=> reg_rdata == {3'b000, level_code};
  endproperty
  a_read_level: assert property (p_read_level) else $error("level readback wrong");

  property p_unimpl_zero;
    @(posedge ref_clk) disable iff (rst)
    ref_ladder_control_r[4] == 1'b0 && ref_ladder_control_r[1] == 1'b0 &&
      ref_ladder_level_r[7:5] == 3'b000;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");

  property p_enable;
    @(posedge ref_clk) disable iff (rst)
    ladder_active == ref_ladder_control_r[RLD_EN_BIT];
  endproperty
  a_enable: assert property (p_enable) else $error("ladder active mismatch");

  property p_pin_read;
    @(posedge ref_clk) disable iff (rst)
    pin_analog_connect |-> !pin_read_value && pin_drv_oe_n && !pin_input_enable;
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("pin not overridden");

  property p_pin_route;
    @(posedge ref_clk) disable iff (rst)
    reg_wr && reg_addr == RLD_CONTROL_OFF && reg_wdata[RLD_OE_BIT] |=> pin_analog_connect;
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("pin not routed");

  property p_low_power;
    @(posedge ref_clk) disable iff (rst)
    !en |-> (lps ? !neg_end_connect && pos_end_connect : !pos_end_connect && neg_end_connect);
  endproperty
  a_low_power: assert property (p_low_power) else $error("wrong end disconnected");

  property p_tap;
    @(posedge ref_clk) disable iff (rst)
    tap_sel == (32'h1 << level_code);
  endproperty
  a_tap: assert property (p_tap) else $error("tap select wrong");

  property p_reset_clear;
    @(posedge ref_clk) $fell(rst) |-> !ladder_active && !pin_analog_connect && level_code == 5'h00;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong");

  // ****************************************
  // Register port checks
  // ****************************************
  // Level write lands at the edge after the strobe, upper bits dropped
  property p_write_level;
    @(posedge ref_clk) disable iff (rst)
    reg_wr && reg_addr == RLD_LEVEL_OFF |=>
      ref_ladder_level_r == ($past(reg_wdata) & RLD_LEVEL_MSK);
  endproperty
  a_write_level: assert property (p_write_level) else $error("level write lost");

  // Control readback shows the value held at the read edge
  property p_read_ctrl;
    @(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == RLD_CONTROL_OFF && !reg_wr |=>
      reg_rdata == $past(ref_ladder_control_r);
  endproperty
  a_read_ctrl: assert property (p_read_ctrl) else $error("control readback wrong");

  // Unmapped indices read as zero
  property p_read_unmapped;
    @(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr != RLD_CONTROL_OFF && reg_addr != RLD_LEVEL_OFF |=>
      reg_rdata == 8'h00;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");

  // Read data stand only one cycle; a bus without a strobe sees zero
  property p_rdata_idle;
    @(posedge ref_clk) disable iff (rst)
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data lingered");

  // Unimplemented control bits never appear on the read bus
  property p_ctrl_read_unimpl;
    @(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == RLD_CONTROL_OFF |=> reg_rdata[4] == 1'b0 && reg_rdata[1] == 1'b0;
  endproperty
  a_ctrl_read_unimpl: assert property (p_ctrl_read_unimpl) else $error("control pad bit");

  // Upper level bits read back as zero
  property p_level_read_unimpl;
    @(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == RLD_LEVEL_OFF |=> reg_rdata[7:5] == 3'b000;
  endproperty
  a_level_read_unimpl: assert property (p_level_read_unimpl) else $error("level pad bit");

  // Nothing but a control write may touch the control settings, sleep included
  property p_ctrl_hold;
    @(posedge ref_clk) disable iff (rst)
    !(reg_wr && reg_addr == RLD_CONTROL_OFF) |=> $stable(ref_ladder_control_r);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed unasked");

  // The level code holds between level writes
  property p_level_hold;
    @(posedge ref_clk) disable iff (rst)
    !(reg_wr && reg_addr == RLD_LEVEL_OFF) |=> $stable(level_code);
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("level changed unasked");

  // ****************************************
  // Ladder and pin checks
  // ****************************************
  // Written enable bit reaches the ladder at the next edge
  property p_enable_write;
    @(posedge ref_clk) disable iff (rst)
    reg_wr && reg_addr == RLD_CONTROL_OFF |=> ladder_active == $past(reg_wdata[RLD_EN_BIT]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable not applied");

  // Written level code reaches the tap decoder at the next edge
  property p_level_write;
    @(posedge ref_clk) disable iff (rst)
    reg_wr && reg_addr == RLD_LEVEL_OFF |=> level_code == $past(reg_wdata[CODE_W-1:0]);
  endproperty
  a_level_write: assert property (p_level_write) else $error("level not applied");

  // Exactly one tap is closed at all times
  property p_tap_onehot;
    @(posedge ref_clk) disable iff (rst)
    $onehot(tap_sel);
  endproperty
  a_tap_onehot: assert property (p_tap_onehot) else $error("tap not one-hot");

  // Source selections follow the written control word
  property p_src_select;
    @(posedge ref_clk) disable iff (rst)
    reg_wr && reg_addr == RLD_CONTROL_OFF |=>
      positive_source_select == $past(reg_wdata[RLD_PSS_LSB +: 2]) &&
      negative_source_select == $past(reg_wdata[RLD_NSS_BIT]);
  endproperty
  a_src_select: assert property (p_src_select) else $error("source select wrong");

  // An enabled ladder keeps both ends tied, so the output is ratiometric
  property p_enabled_ends;
    @(posedge ref_clk) disable iff (rst)
    ladder_active |-> pos_end_connect && neg_end_connect;
  endproperty
  a_enabled_ends: assert property (p_enabled_ends) else $error("end open while enabled");

  // High clamp: only the positive end tied and the top tap closed
  property p_clamp_pos;
    @(posedge ref_clk) disable iff (rst)
    !ladder_active && lps && level_code == '1 |->
      pos_end_connect && !neg_end_connect && tap_sel[(1<<CODE_W)-1];
  endproperty
  a_clamp_pos: assert property (p_clamp_pos) else $error("high clamp wrong");

  // Low clamp: only the negative end tied and the bottom tap closed
  property p_clamp_neg;
    @(posedge ref_clk) disable iff (rst)
    !ladder_active && !lps && level_code == '0 |->
      !pos_end_connect && neg_end_connect && tap_sel[0];
  endproperty
  a_clamp_neg: assert property (p_clamp_neg) else $error("low clamp wrong");

  // The level always reaches comparator and converter channel
  property p_fanout;
    @(posedge ref_clk) disable iff (rst)
    comparator_ref_valid && converter_ch_valid;
  endproperty
  a_fanout: assert property (p_fanout) else $error("level not fanned out");

  // Clearing the pin enable hands the pin back to the port logic
  property p_pin_route_off;
    @(posedge ref_clk) disable iff (rst)
    reg_wr && reg_addr == RLD_CONTROL_OFF && !reg_wdata[RLD_OE_BIT] |=> !pin_analog_connect;
  endproperty
  a_pin_route_off: assert property (p_pin_route_off) else $error("pin not released");

  // A released pin passes the port logic through untouched
  property p_pin_release;
    @(posedge ref_clk) disable iff (rst)
    !pin_analog_connect |-> pin_drv_oe_n == pin_port_oe_n && pin_drv_out == pin_port_out &&
      pin_input_enable && pin_read_value == pin_digital_in;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("pin path blocked");

  // The digital driver stays quiet while the pin carries the level
  property p_pin_drive_off;
    @(posedge ref_clk) disable iff (rst)
    pin_analog_connect |-> !pin_drv_out;
  endproperty
  a_pin_drive_off: assert property (p_pin_drive_off) else $error("pin driven digitally");

  // Right after reset the pin is digital again
  property p_reset_pin;
    @(posedge ref_clk) $fell(rst) |-> pin_input_enable && pin_read_value == pin_digital_in;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("pin held after reset");

  c_enable:  cover property (@(posedge ref_clk) disable iff (rst) $rose(ladder_active));
  c_pin:     cover property (@(posedge ref_clk) disable iff (rst) $rose(pin_analog_connect));
  c_clamp_p: cover property (@(posedge ref_clk) disable iff (rst) !en && lps && level_code == 5'h1f);
  c_clamp_n: cover property (@(posedge ref_clk) disable iff (rst) !en && !lps && level_code == 5'h00);
endmodule : rld_ladder_control

// ===== design/rld_switch_decode.sv
// One-hot ladder tap decoder for the analog switch array
// Assumes the tap code is registered upstream
`timescale 1ns/1ps
module rld_switch_decode
  import rld_pkg::*;
#(
  parameter int CODE_W = RLD_CODE_W
) (
  input  wire logic [CODE_W-1:0]    code,
  input  wire logic                 active,
  output logic      [(1<<CODE_W)-1:0] tap_sel
);
  // One tap closed per code; all open when active is low
  always_comb begin
    tap_sel = '0;
    if (active) begin
      tap_sel[code] = 1'b1;
    end
  end
endmodule : rld_switch_decode

// ===== include/rld_pkg.sv
// Package for the resistor-ladder reference control block
// Assumes one system clock; register offsets here are local indices on the plain port
package rld_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] RLD_CONTROL_OFF = 4'h0;
  localparam logic [3:0] RLD_LEVEL_OFF   = 4'h1;
  // ****************************************
  // Field positions and masks
  // ****************************************
  localparam int         RLD_EN_BIT      = 7;
  localparam int         RLD_LPS_BIT     = 6;
  localparam int         RLD_OE_BIT      = 5;
  localparam int         RLD_PSS_LSB     = 2;
  localparam int         RLD_NSS_BIT     = 0;
  localparam logic [7:0] RLD_CONTROL_MSK = 8'hed;
  localparam logic [7:0] RLD_LEVEL_MSK   = 8'h1f;
  localparam logic [7:0] RLD_CONTROL_RST = 8'h00;
  localparam logic [7:0] RLD_LEVEL_RST   = 8'h00;
  localparam int         RLD_CODE_W      = 5;
  localparam int         RLD_LEVELS      = 32;
  // ****************************************
  // Source encodings
  // ****************************************
  typedef enum logic [1:0] {
    RLD_PSRC_SUPPLY = 2'b00,
    RLD_PSRC_EXTREF = 2'b01,
    RLD_PSRC_FIXED  = 2'b10,
    RLD_PSRC_RSVD   = 2'b11
  } rld_psrc_type;
endpackage : rld_pkg

// ===== tb/rld_ladder_control_test.sv
// Self-checking bench for the resistor-ladder reference control block
// Assumes the plain register port and a free-running 125 MHz ref_clk
`timescale 1ns/1ps
module rld_ladder_control_test
  import rld_pkg::*;
;
  logic        ref_clk, rst, reg_wr, reg_rd, pin_digital_in, pin_port_out, pin_port_oe_n;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, c;
  logic        pin_read_value, pin_drv_out, pin_drv_oe_n, pin_input_enable, pin_analog_connect;
  logic        ladder_active, pos_end_connect, neg_end_connect, negative_source_select;
  logic        comparator_ref_valid, converter_ch_valid;
  logic [1:0]  positive_source_select;
  logic [4:0]  level_code;
  logic [31:0] tap_sel;
  int          fails, checked;
  rld_ladder_control rld_ladder_control_i (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_digital_in(pin_digital_in), .pin_port_out(pin_port_out),
    .pin_port_oe_n(pin_port_oe_n), .pin_read_value(pin_read_value), .pin_drv_out(pin_drv_out),
    .pin_drv_oe_n(pin_drv_oe_n), .pin_input_enable(pin_input_enable),
    .pin_analog_connect(pin_analog_connect), .ladder_active(ladder_active),
    .pos_end_connect(pos_end_connect), .neg_end_connect(neg_end_connect),
    .positive_source_select(positive_source_select),
    .negative_source_select(negative_source_select), .level_code(level_code),
    .tap_sel(tap_sel), .comparator_ref_valid(comparator_ref_valid),
    .converter_ch_valid(converter_ch_valid));
  // ****************************************
  // Clock, reset and shared tasks
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One-cycle write strobe; a gap cycle follows before the next request
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd
  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  // Watchdog sized well above the few hundred cycles the tests need
  initial begin
    repeat (6000) @(posedge ref_clk);
    fails++;
    test_done;
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00;
    pin_digital_in = 1'b1; pin_port_out = 1'b1; pin_port_oe_n = 1'b0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    rd(RLD_CONTROL_OFF, 8'h00);
    rd(RLD_LEVEL_OFF, 8'h00);
    chk({ladder_active, pin_analog_connect, tap_sel[0]}, 3'b001);
    // Every source, low-power and enable combination with the pin left digital
    for (int i = 0; i < 32; i++) begin
      c = {i[4], i[3], 2'b00, i[2:1], 1'b0, i[0]};
      pin_digital_in <= i[0]; pin_port_out <= i[1]; pin_port_oe_n <= i[2];
      wr(RLD_CONTROL_OFF, c | 8'h12);
      rd(RLD_CONTROL_OFF, c);
      chk({positive_source_select, negative_source_select}, {c[3:2], c[0]});
      chk(ladder_active, c[7]);
      chk({pos_end_connect, neg_end_connect}, c[7] ? 2'b11 : {c[6], ~c[6]});
      chk({pin_read_value, pin_drv_out, pin_drv_oe_n}, {i[0], i[1], i[2]});
      chk({comparator_ref_valid, converter_ch_valid, pin_input_enable}, 3'b111);
    end
    // Every level code, with the unimplemented upper bits written as ones
    for (int k = 0; k < RLD_LEVELS; k++) begin
      wr(RLD_LEVEL_OFF, {3'b111, k[4:0]});
      rd(RLD_LEVEL_OFF, {3'b000, k[4:0]});
      chk(level_code, k[4:0]);
      chk(tap_sel, 32'h1 << k);
    end
    // Clamp to the positive end at minimum power, fixed reference chosen
    wr(RLD_CONTROL_OFF, 8'h48);
    wr(RLD_LEVEL_OFF, 8'h1f);
    chk({ladder_active, pos_end_connect, neg_end_connect, tap_sel[31]}, 4'b0101);
    chk(positive_source_select, RLD_PSRC_FIXED);
    // Clamp to the negative end at minimum power, external negative chosen
    wr(RLD_CONTROL_OFF, 8'h01);
    wr(RLD_LEVEL_OFF, 8'h00);
    chk({ladder_active, pos_end_connect, neg_end_connect, tap_sel[0]}, 4'b0011);
    chk(negative_source_select, 1'b1);
    wr(RLD_LEVEL_OFF, 8'h15);
    // Pin carries the level: digital paths overridden while the input is high
    pin_digital_in <= 1'b1; pin_port_out <= 1'b1; pin_port_oe_n <= 1'b0;
    wr(RLD_CONTROL_OFF, 8'hff);
    rd(RLD_CONTROL_OFF, RLD_CONTROL_MSK);
    chk(pin_analog_connect, 1'b1);
    chk({pin_drv_oe_n, pin_drv_out, pin_input_enable}, 3'b100);
    chk(pin_read_value, 1'b0);
    // Unmapped index is ignored on write and reads zero
    wr(4'h2, 8'h00);
    rd(4'h2, 8'h00);
    rd(4'hf, 8'h00);
    rd(RLD_CONTROL_OFF, RLD_CONTROL_MSK);
    // Software parks the ladder before sleep; an idle stretch stands in for sleep
    wr(RLD_CONTROL_OFF, 8'h6d);
    repeat (50) @(posedge ref_clk);
    rd(RLD_CONTROL_OFF, 8'h6d);
    chk(ladder_active, 1'b0);
    // Reset in mid-run clears everything again
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk({ladder_active, pin_analog_connect, level_code}, 7'h00);
    @(posedge ref_clk);
    rst <= 1'b0;
    rd(RLD_LEVEL_OFF, 8'h00);
    rd(RLD_CONTROL_OFF, 8'h00);
    chk(pin_read_value, 1'b1);
    test_done;
  end
endmodule : rld_ladder_control_test
